// *** logic/twm_status_regs.v ***
// Notes on behaviour
// RULE_01: Receive field holds bus byte while ready
// RULE_02: Transmit holder write supplies byte to send
// RULE_03: Transmit-ready bit 1; status resets to 2
// RULE_04: Transmit-ready drops when full or stopped
// RULE_05: Receive-ready bit 0 while byte waits
// RULE_06: Command-ready bit 2 while a slot free
// RULE_07: Command-complete bit 3 on success only
// RULE_08: Idle bit 4 when no command pending
// RULE_09: Bus-free bit 5 after bus activity ends
// RULE_10: Address NAK sets bit 8
// RULE_11: Data NAK sets bit 9
// RULE_12: Arbitration loss sets bit 10
// RULE_13: Bus timeout sets bit 12
// RULE_14: Checksum mismatch sets bit 13
// RULE_15: Accepted stop request sets bit 14
// RULE_16: Bit 16 shows master enable
// RULE_17: Master-code acknowledge sets bit 17
// RULE_18: Enable-set write ones set mask bits
// RULE_19: Enable-clear write ones clear mask bits
// RULE_20: Mask bits gate sources; reset zero
// RULE_21: Clear register ones clear sticky flags
// RULE_22: Interrupt when any flag and mask set
// RULE_23: Next slot promoted when current invalid
`timescale 1ns/1ps
module twm_status_regs (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_clk_en,
  // Avalon-MM slave
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  // Two-wire lines and intended data level
  input  wire        i_scl,
  input  wire        i_sda,
  input  wire        i_sda_want_high,
  // Protocol engine events, one-cycle pulses
  input  wire        i_rx_strobe,
  input  wire [7:0]  i_rx_byte,
  input  wire        i_tx_take,
  input  wire        i_evt_cmd_ok,
  input  wire        i_evt_addr_nak,
  input  wire        i_evt_data_nak,
  input  wire        i_evt_timeout,
  input  wire        i_evt_pec_err,
  input  wire        i_evt_stop_ok,
  input  wire        i_evt_mcode_ack,
  // Towards the protocol engine and system
  output reg  [7:0]  o_tx_byte,
  output reg         o_tx_full,
  output wire [31:0] o_cur_cmd,
  output reg         o_master_en,
  output reg         o_stop_req,
  output reg         o_irq
);
`include "twm_defines.vh"

  // Byte-enable expansion to a bit mask
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Merge enabled byte lanes of new data into an old word
  function [31:0] lane_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0]  be;
    begin
      lane_merge = (old_w & ~be_mask(be)) | (new_w & be_mask(be));
    end
  endfunction

  reg  [31:0] irq_mask_r;
  reg  [31:0] sticky_r;
  reg  [31:0] sticky_nxt;
  reg  [7:0]  rx_byte_r;
  reg         rx_full_r;
  reg         stopped_r;
  reg  [31:0] rd_val;
  reg  [31:0] status_w;
  wire [31:0] next_cmd;
  wire        bus_free;
  wire        arb_lost;

  // Bus handshake: one wait cycle, then access on the low-wait edge
  wire        req     = i_avs_read | i_avs_write;
  wire        acc     = req & ~o_avs_waitrequest;
  wire        wr_acc  = acc & i_avs_write;
  wire        rd_acc  = acc & i_avs_read;
  wire [31:0] wd_m    = i_avs_writedata & be_mask(i_avs_byteenable);

  // Write strobes per register and the receive-holder read strobe
  wire cur_wr   = wr_acc & (i_avs_address == `TWM_OFF_CUR_CMD);
  wire next_wr  = wr_acc & (i_avs_address == `TWM_OFF_NEXT_CMD);
  wire tx_wr    = wr_acc & (i_avs_address == `TWM_OFF_TX_HOLDER) & i_avs_byteenable[0];
  wire iset_wr  = wr_acc & (i_avs_address == `TWM_OFF_IRQ_SET);
  wire iclr_wr  = wr_acc & (i_avs_address == `TWM_OFF_IRQ_CLR);
  wire sclr_wr  = wr_acc & (i_avs_address == `TWM_OFF_STAT_CLR);
  wire ctrl_wr  = wr_acc & (i_avs_address == `TWM_OFF_CTRL);
  wire rx_rd    = rd_acc & (i_avs_address == `TWM_OFF_RX_HOLDER);

  // Address NAK, data NAK, arbitration loss or timeout ends the command without success
  wire fail_ev  = i_evt_addr_nak | i_evt_data_nak | arb_lost | i_evt_timeout;
  wire finish   = i_evt_cmd_ok | fail_ev;

  wire cur_valid  = o_cur_cmd[`TWM_CMD_VALID];
  wire next_valid = next_cmd[`TWM_CMD_VALID];

  // Command slots with promotion of the waiting command
  twm_cmd_slots u_slots (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_clk_en     (i_clk_en),
    .i_cur_wr     (cur_wr),
    .i_cur_wdata  (lane_merge(o_cur_cmd, i_avs_writedata, i_avs_byteenable)),
    .i_next_wr    (next_wr),
    .i_next_wdata (lane_merge(next_cmd, i_avs_writedata, i_avs_byteenable)),
    .i_cmd_finish (finish),                 // RULE_23
    .o_cur_cmd    (o_cur_cmd),
    .o_next_cmd   (next_cmd)
  );

  // Line watcher for bus state and arbitration
  twm_bus_monitor u_mon (
    .i_sys_clk       (i_sys_clk),
    .i_rst_n         (i_rst_n),
    .i_clk_en        (i_clk_en),
    .i_scl           (i_scl),
    .i_sda           (i_sda),
    .i_sda_want_high (i_sda_want_high),
    .o_bus_free      (bus_free),
    .o_arb_lost      (arb_lost)
  );

  // Sticky event flags; a set in the clearing cycle wins
  always @* begin
    sticky_nxt = sticky_r;
    if (sclr_wr) begin
      sticky_nxt = sticky_nxt & ~(wd_m & `TWM_STICKY_BITS);      // RULE_21
    end
    if (i_evt_cmd_ok && !fail_ev) begin
      sticky_nxt[`TWM_SR_COMMAND_COMPLETE_FLAG] = 1'b1;                          // RULE_07
    end
    if (i_evt_addr_nak) begin
      sticky_nxt[`TWM_SR_ADDRESS_NAK_FLAG] = 1'b1;                           // RULE_10
    end
    if (i_evt_data_nak) begin
      sticky_nxt[`TWM_SR_DATA_NAK_FLAG] = 1'b1;                           // RULE_11
    end
    if (arb_lost) begin
      sticky_nxt[`TWM_SR_ARBITRATION_LOST_FLAG] = 1'b1;                         // RULE_12
    end
    if (i_evt_timeout) begin
      sticky_nxt[`TWM_SR_SMBUS_TIMEOUT_FLAG] = 1'b1;                           // RULE_13
    end
    if (i_evt_pec_err) begin
      sticky_nxt[`TWM_SR_CHECKSUM_ERROR_FLAG] = 1'b1;                         // RULE_14
    end
    if (i_evt_stop_ok) begin
      sticky_nxt[`TWM_SR_STOP] = 1'b1;                           // RULE_15
    end
    if (i_evt_mcode_ack) begin
      sticky_nxt[`TWM_SR_MCACK] = 1'b1;                          // RULE_17
    end
  end

  // Live status word: sticky flags plus level flags
  always @* begin
    status_w                    = sticky_r;
    status_w[`TWM_SR_RX_READY_FLAG]     = rx_full_r;                      // RULE_05
    status_w[`TWM_SR_TX_READY_FLAG]     = ~o_tx_full & ~stopped_r;        // RULE_03 RULE_04
    status_w[`TWM_SR_COMMAND_READY_FLAG]      = o_master_en & ~(cur_valid & next_valid); // RULE_06
    status_w[`TWM_SR_IDLE]      = o_master_en & ~cur_valid & ~next_valid;  // RULE_08
    status_w[`TWM_SR_BUS_FREE_FLAG]   = bus_free;                       // RULE_09
    status_w[`TWM_SR_MASTER_ENABLED_FLAG]      = o_master_en;                    // RULE_16
  end

  // Read mux; unmapped and write-only offsets read zero
  always @* begin
    rd_val = `TWM_ZERO;
    if (i_avs_address == `TWM_OFF_CUR_CMD) begin
      rd_val = o_cur_cmd;
    end else if (i_avs_address == `TWM_OFF_NEXT_CMD) begin
      rd_val = next_cmd;
    end else if (i_avs_address == `TWM_OFF_RX_HOLDER) begin
      rd_val = {24'h00_0000, rx_byte_r};                          // RULE_01
    end else if (i_avs_address == `TWM_OFF_STATUS) begin
      rd_val = status_w;
    end else if (i_avs_address == `TWM_OFF_IRQ_MASK) begin
      rd_val = irq_mask_r;                                        // RULE_20
    end else if (i_avs_address == `TWM_OFF_CTRL) begin
      rd_val = {31'h0000_0000, o_master_en};
    end
  end

  // Bus slave handshake and read data capture
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= `TWM_ZERO;
    end else if (i_clk_en) begin
      if (req && o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata    <= rd_val;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

  // Mask, sticky flags and control
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_r  <= `TWM_MASK_RST;
      sticky_r    <= `TWM_ZERO;
      o_master_en <= 1'b0;
      o_stop_req  <= 1'b0;
    end else if (i_clk_en) begin
      sticky_r <= sticky_nxt;
      if (iset_wr) begin
        irq_mask_r <= irq_mask_r | (wd_m & `TWM_MASK_BITS);       // RULE_18
      end else if (iclr_wr) begin
        irq_mask_r <= irq_mask_r & ~(wd_m & `TWM_MASK_BITS);      // RULE_19
      end
      if (ctrl_wr && i_avs_byteenable[0]) begin
        o_master_en <= i_avs_writedata[`TWM_CTRL_EN];
      end
      o_stop_req <= ctrl_wr & wd_m[`TWM_CTRL_STOP];
    end
  end

  // Receive holder: a new byte wins over a clearing read
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_byte_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (i_clk_en) begin
      if (i_rx_strobe) begin
        rx_byte_r <= i_rx_byte;                                   // RULE_01
        rx_full_r <= 1'b1;                                        // RULE_05
      end else if (rx_rd) begin
        rx_full_r <= 1'b0;                                        // RULE_05
      end
    end
  end

  // Transmit holder: write fills, engine take empties
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_byte <= 8'h00;
      o_tx_full <= 1'b0;
      stopped_r <= 1'b0;
    end else if (i_clk_en) begin
      if (tx_wr) begin
        o_tx_byte <= i_avs_writedata[7:0];                        // RULE_02
        o_tx_full <= 1'b1;                                        // RULE_04
      end else if (i_tx_take) begin
        o_tx_full <= 1'b0;
      end
      if (i_evt_stop_ok) begin
        stopped_r <= 1'b1;                                        // RULE_04
      end else if (cur_wr || next_wr) begin
        stopped_r <= 1'b0;
      end
    end
  end

  // Interrupt line from flags gated by the mask
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |(status_w & irq_mask_r);                          // RULE_20 RULE_22
    end
  end
endmodule // twm_status_regs

// *** logic/twm_defines.vh ***
`ifndef TWM_DEFINES_VH
`define TWM_DEFINES_VH

// Register byte offsets
`define TWM_OFF_CUR_CMD      8'h0c
`define TWM_OFF_NEXT_CMD     8'h10
`define TWM_OFF_RX_HOLDER    8'h14
`define TWM_OFF_TX_HOLDER    8'h18
`define TWM_OFF_STATUS       8'h1c
`define TWM_OFF_IRQ_SET      8'h20
`define TWM_OFF_IRQ_CLR      8'h24
`define TWM_OFF_IRQ_MASK     8'h28
`define TWM_OFF_STAT_CLR     8'h2c
`define TWM_OFF_CTRL         8'h44

// Status bit positions
`define TWM_SR_RX_READY_FLAG         0
`define TWM_SR_TX_READY_FLAG         1
`define TWM_SR_COMMAND_READY_FLAG          2
`define TWM_SR_COMMAND_COMPLETE_FLAG         3
`define TWM_SR_IDLE          4
`define TWM_SR_BUS_FREE_FLAG       5
`define TWM_SR_ADDRESS_NAK_FLAG          8
`define TWM_SR_DATA_NAK_FLAG          9
`define TWM_SR_ARBITRATION_LOST_FLAG        10
`define TWM_SR_SMBUS_TIMEOUT_FLAG          12
`define TWM_SR_CHECKSUM_ERROR_FLAG        13
`define TWM_SR_STOP          14
`define TWM_SR_MASTER_ENABLED_FLAG          16
`define TWM_SR_MCACK         17

// Reset values and writable bit sets
`define TWM_STATUS_RST       32'h0000_0002
`define TWM_MASK_RST         32'h0000_0000
`define TWM_MASK_BITS        32'h0002_773f
`define TWM_STICKY_BITS      32'h0002_7708
`define TWM_ZERO             32'h0000_0000

// Control register fields and command slot valid bit
`define TWM_CTRL_EN          0
`define TWM_CTRL_STOP        1
`define TWM_CMD_VALID        15

`endif

// *** logic/twm_cmd_slots.v ***
`timescale 1ns/1ps
module twm_cmd_slots (
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  input  wire        i_clk_en,
  input  wire        i_cur_wr,
  input  wire [31:0] i_cur_wdata,
  input  wire        i_next_wr,
  input  wire [31:0] i_next_wdata,
  input  wire        i_cmd_finish,
  output reg  [31:0] o_cur_cmd,
  output reg  [31:0] o_next_cmd
);
`include "twm_defines.vh"

  reg [31:0] cur_nxt;
  reg [31:0] next_nxt;

  // Slot update, finish, then promotion of the waiting command
  always @* begin
    cur_nxt  = o_cur_cmd;
    next_nxt = o_next_cmd;
    if (i_cur_wr) begin
      cur_nxt = i_cur_wdata;
    end
    if (i_next_wr) begin
      next_nxt = i_next_wdata;
    end
    if (i_cmd_finish) begin
      cur_nxt[`TWM_CMD_VALID] = 1'b0;
    end
    if (!cur_nxt[`TWM_CMD_VALID] && next_nxt[`TWM_CMD_VALID]) begin
      cur_nxt                  = next_nxt; // RULE_23
      next_nxt[`TWM_CMD_VALID] = 1'b0;     // RULE_23
    end
  end

  // Slot flops
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cur_cmd  <= `TWM_ZERO;
      o_next_cmd <= `TWM_ZERO;
    end else if (i_clk_en) begin
      o_cur_cmd  <= cur_nxt;
      o_next_cmd <= next_nxt;
    end
  end
endmodule // twm_cmd_slots

// *** logic/twm_bus_monitor.v ***
`timescale 1ns/1ps
module twm_bus_monitor (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_clk_en,
  input  wire i_scl,
  input  wire i_sda,
  input  wire i_sda_want_high,
  output reg  o_bus_free,
  output reg  o_arb_lost
);

  reg scl_s1_r;
  reg scl_s2_r;
  reg scl_d_r;
  reg sda_s1_r;
  reg sda_s2_r;
  reg sda_d_r;

  // Start, stop and clock rise seen on synchronised lines only
  wire scl_hi   = scl_s2_r & scl_d_r;
  wire start_ev = scl_hi & sda_d_r & ~sda_s2_r;
  wire stop_ev  = scl_hi & ~sda_d_r & sda_s2_r;
  wire scl_rise = scl_s2_r & ~scl_d_r;

  // Two-stage synchronisers, then a delay stage for edges
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else if (i_clk_en) begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  // Bus state at start and stop, arbitration check at each clock rise
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bus_free <= 1'b0;
      o_arb_lost <= 1'b0;
    end else if (i_clk_en) begin
      if (start_ev) begin
        o_bus_free <= 1'b0;  // RULE_09
      end else if (stop_ev) begin
        o_bus_free <= 1'b1;  // RULE_09
      end
      o_arb_lost <= scl_rise & i_sda_want_high & ~sda_s2_r; // RULE_12
    end
  end
endmodule // twm_bus_monitor

// *** testbench/twm_monitor.sv ***
`timescale 1ns/1ps
module twm_monitor (
  input wire        i_sys_clk,
  input wire        i_rst_n,
  input wire        i_clk_en,
  input wire [7:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        i_tx_take,
  input wire [7:0]  o_tx_byte,
  input wire        o_tx_full,
  input wire        o_master_en,
  input wire        o_stop_req
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  // Bus cycle qualifiers
  wire tx_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h18
               && i_avs_byteenable[0];
  wire rd_ok = i_avs_read && !o_avs_waitrequest;

  // Handshake timing
  wait_one_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("wait low longer than one cycle");
  wait_ans_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("request not answered");

  // Transmit holder
  tx_load_a: assert property (tx_wr |=> o_tx_full &&
    o_tx_byte == $past(i_avs_writedata[7:0])) else $error("tx byte not loaded");
  tx_take_a: assert property (i_tx_take && !tx_wr |=> !o_tx_full)
    else $error("tx holder still full");
  tx_rdy_a: assert property (rd_ok && i_avs_address == 8'h1c && $past(o_tx_full)
    |-> !o_avs_readdata[1]) else $error("tx ready while full");

  // Status and mask read contents, stop request pulse
  stat_rsv_a: assert property (rd_ok && i_avs_address == 8'h1c
    |-> (o_avs_readdata & 32'hfffc_88c0) == 32'h0000_0000) else $error("status reserved");
  mask_rsv_a: assert property (rd_ok && i_avs_address == 8'h28
    |-> (o_avs_readdata & 32'hfffd_88c0) == 32'h0000_0000) else $error("mask reserved");
  master_enabled_flag_bit_a: assert property (rd_ok && i_avs_address == 8'h1c
    |-> o_avs_readdata[16] == $past(o_master_en)) else $error("enable bit wrong");
  stop_one_a: assert property (o_stop_req |=> !o_stop_req)
    else $error("stop request not a pulse");
  stop_set_a: assert property (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h44
    && i_avs_byteenable[0] && i_avs_writedata[1] |=> o_stop_req)
    else $error("stop request not raised");

  // Main scenarios
  cover property (tx_wr);
  cover property (rd_ok && i_avs_address == 8'h14);
  cover property ($rose(o_master_en));
endmodule // twm_monitor

// *** testbench/twm_bus_model.sv ***
`timescale 1ns/1ps
module twm_bus_model (
  input  wire i_go,
  input  wire i_lose,
  output reg  o_scl,
  output reg  o_sda
);
  // Frame: start, four bits, stop; clock still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    forever begin
      @(posedge i_go);
      #37 o_sda = 1'b0; // Start: data falls, clock high
      repeat (4) begin
        #80 o_scl = 1'b0;
        o_sda = i_lose ? 1'b0 : ~o_sda; // Data moves only while clock low
        #80 o_scl = 1'b1;
      end
      #80 o_scl = 1'b0;
      o_sda = 1'b0;
      #80 o_scl = 1'b1;
      #80 o_sda = 1'b1; // Stop: data rises, clock high
    end
  end
endmodule // twm_bus_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam [34:0] SB = {5'd17, 5'd14, 5'd13, 5'd12, 5'd9, 5'd8, 5'd3};
  reg         clk, rst_n, rd_r, we_r, want, go, lose;
  reg  [7:0]  adr, rxb;
  reg  [31:0] wd, q;
  reg  [3:0]  be;
  reg  [8:0]  ev;
  wire [31:0] rdat, cur;
  wire [7:0]  txb;
  wire        wreq, full, men, irq, scl, sda;
  integer     failures, n_compared, i;

  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  twm_status_regs dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_avs_address(adr), .i_avs_read(rd_r), .i_avs_write(we_r), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_scl(scl), .i_sda(sda), .i_sda_want_high(want), .i_rx_strobe(ev[7]),
    .i_rx_byte(rxb), .i_tx_take(ev[8]), .i_evt_cmd_ok(ev[0]), .i_evt_addr_nak(ev[1]),
    .i_evt_data_nak(ev[2]), .i_evt_timeout(ev[3]), .i_evt_pec_err(ev[4]),
    .i_evt_stop_ok(ev[5]), .i_evt_mcode_ack(ev[6]), .o_tx_byte(txb), .o_tx_full(full),
    .o_cur_cmd(cur), .o_master_en(men), .o_stop_req(), .o_irq(irq));

  twm_bus_model bus_u (.i_go(go), .i_lose(lose), .o_scl(scl), .o_sda(sda));

  // Compare and count
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task chk1(input string nm, input s, input e); chk(nm, {31'd0, s}, {31'd0, e}); endtask

  task finish_test;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task xfer(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk);
      rd_r <= !w;
      we_r <= w;
      adr <= a;
      wd <= d;
      k = 0;
      @(posedge clk);
      while (wreq !== 1'b0 && k < 50) begin
        @(posedge clk);
        k = k + 1;
      end
      if (k == 50) begin
        failures = failures + 1;
        finish_test;
      end
      q = rdat;
      rd_r <= 1'b0;
      we_r <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d); xfer(1'b1, a, d); endtask
  task rd(input [7:0] a); xfer(1'b0, a, 32'h0000_0000); endtask

  // One-cycle engine pulses
  task pulse(input [8:0] v);
    begin
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 9'h000;
    end
  endtask

  // Run limit
  initial begin
    #500_000;
    failures = failures + 1;
    finish_test;
  end

  // Main sequence
  initial begin
    {rst_n, rd_r, we_r, want, go, lose} = 6'd0;
    {adr, rxb, wd, ev} = 57'd0;
    be = 4'hf;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h1c); chk("status rst", q, 32'h0000_0002);
    rd(8'h28); chk("mask rst", q, 32'h0000_0000);
    rd(8'h30); chk("unmapped", q, 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff); rd(8'h28); chk("mask set", q, 32'h0002_773f);
    wr(8'h24, 32'h0000_0001); rd(8'h28); chk("mask clr", q, 32'h0002_773e);
    wr(8'h24, 32'h0000_0000); rd(8'h28); chk("mask keep", q, 32'h0002_773e);
    wr(8'h24, 32'hffff_ffff); wr(8'h20, 32'h0002_7708);
    // Transmit holder: lane 0 needed, then full, then taken
    be <= 4'he; wr(8'h18, 32'h0000_005a); be <= 4'hf;
    rd(8'h1c); chk1("tx lane", q[1], 1'b1);
    wr(8'h18, 32'h0000_00a5); @(negedge clk);
    chk("tx byte", {24'd0, txb}, 32'h0000_00a5); chk1("tx full", full, 1'b1);
    rd(8'h1c); chk1("tx rdy full", q[1], 1'b0);
    pulse(9'h100); rd(8'h1c); chk1("tx rdy", q[1], 1'b1);
    // Receive holder
    rxb <= 8'h3c; pulse(9'h080);
    rd(8'h1c); chk1("rx rdy", q[0], 1'b1);
    rd(8'h14); chk("rx byte", q, 32'h0000_003c);
    rd(8'h1c); chk1("rx rdy clr", q[0], 1'b0);
    // Command slots with master enabled
    wr(8'h44, 32'h0000_0001); rd(8'h1c); chk1("enable", men, 1'b1);
    chk("en rdy idle", {29'd0, q[16], q[4], q[2]}, 32'h0000_0007);
    wr(8'h0c, 32'h0000_8012); wr(8'h10, 32'h0000_8034); rd(8'h1c);
    chk("slots full", {30'd0, q[4], q[2]}, 32'h0000_0000);
    pulse(9'h001); rd(8'h1c); chk("promote", cur, 32'h0000_8034);
    chk("ok rdy", {30'd0, q[3], q[2]}, 32'h0000_0003);
    pulse(9'h001); rd(8'h1c); chk1("idle", q[4], 1'b1);
    wr(8'h2c, 32'h0000_0008); wr(8'h0c, 32'h0000_8012); pulse(9'h003); rd(8'h1c);
    chk("fail", {30'd0, q[8], q[3]}, 32'h0000_0002);
    wr(8'h2c, 32'h0000_0100);
    // Each sticky flag except arbitration lost: set, interrupt, clear
    for (i = 0; i < 7; i = i + 1) begin
      pulse(9'd1 << i); rd(8'h1c);
      chk1("flag", q[SB[i*5 +: 5]], 1'b1);
      chk1("irq on", irq, 1'b1);
      wr(8'h2c, 32'h0000_0001 << SB[i*5 +: 5]); rd(8'h1c);
      chk1("flag clr", q[SB[i*5 +: 5]], 1'b0); chk1("irq off", irq, 1'b0);
    end
    // Stop event left transmit closed; a next-slot write lands in an empty current slot
    rd(8'h1c); chk1("tx stopped", q[1], 1'b0);
    wr(8'h10, 32'h0000_8056); rd(8'h0c); chk("direct", q, 32'h0000_8056);
    // Mask gates the interrupt
    wr(8'h24, 32'h0000_0100); pulse(9'h002); rd(8'h1c); chk1("masked", irq, 1'b0);
    wr(8'h20, 32'h0000_0100); rd(8'h1c); chk1("unmasked", irq, 1'b1);
    wr(8'h2c, 32'h0000_0100);
    // Bus frames: plain, then one lost to another master
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      go <= 1'b1;
      lose <= i[0];
      want <= i[0];
      repeat (30) @(posedge clk);
      go <= 1'b0;
      rd(8'h1c); chk1("busy", q[5], 1'b0);
      repeat (100) @(posedge clk);
      rd(8'h1c); chk1("free", q[5], 1'b1);
      chk1("arb", q[10], i[0]);
    end
    wr(8'h44, 32'h0000_0003); rd(8'h1c); chk1("still en", q[16], 1'b1);
    finish_test;
  end
endmodule // testbench

bind twm_status_regs twm_monitor mon_u (.i_sys_clk, .i_rst_n, .i_clk_en, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
  .o_avs_waitrequest, .i_tx_take, .o_tx_byte, .o_tx_full, .o_master_en, .o_stop_req);
